// *** bench/relay_load.sv ***
// Behavioural relay load with injectable short, heat and open-wire faults
`timescale 1ns/1ps
module relay_load (
    input  wire logic [1:0] sw_out,
    input  wire logic [1:0] short_cmd,
    input  wire logic [1:0] hot_cmd,
    input  wire logic [1:0] warm_cmd,
    input  wire logic [1:0] open_cmd,
    output logic      [1:0] oc_det,
    output logic      [1:0] ot_det,
    output logic      [1:0] ol_det,
    output logic      [1:0] ot_warn
);
    // A short only draws current while the switch conducts
    assign oc_det  = short_cmd & sw_out;
    // Die heat lingers whatever the switch does, so no gating here
    assign ot_det  = hot_cmd;
    assign ot_warn = warm_cmd;
    assign ol_det  = open_cmd;
endmodule : relay_load

// *** bench/testbench.sv ***
// Self-checking bench for the low-side switch control block
`timescale 1ns/1ps
module testbench
    import lss_pkg::*;
;
    logic        ref_clk, rst_n, wr_en, rd_en, low_power, irq;
    logic [7:0]  addr, pwm_chan;
    logic [31:0] wdata, rdata;
    logic [1:0]  sw_out, sw_fast_slew, ol_det_en, oc_det, ot_det, ol_det, ot_warn;
    logic [1:0]  short_cmd, hot_cmd, warm_cmd, open_cmd;
    logic [3:0]  oc_thresh;
    logic [31:0] m_ctrl, m_sts, m_ien, m_src, m_trim1, m_trim2;
    logic        m_lp;
    int          n_fail, n_compared;

    low_side_switch_control u_dut (.ref_clk, .rst_n, .addr, .wdata, .wr_en, .rd_en,
        .rdata, .pwm_chan, .low_power, .oc_det, .ot_det, .ol_det, .ot_warn, .sw_out,
        .sw_fast_slew, .oc_thresh, .ol_det_en, .irq);
    relay_load u_load (.sw_out, .short_cmd, .hot_cmd, .warm_cmd, .open_cmd, .oc_det,
        .ot_det, .ol_det, .ot_warn);

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Bus write; the model register file follows the same access rules
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        case (a)
            CTRL_OFS:  m_ctrl = d & {CTRL_MASK, CTRL_MASK};
            CLR_OFS:   m_sts = m_sts & ~d;
            IEN_OFS:   m_ien = d & {IEN_MASK, IEN_MASK};
            TRIM1_OFS: m_trim1 = d & TRIM_MASK;
            TRIM2_OFS: m_trim2 = d & TRIM_MASK;
            SRC_OFS: begin
                // Selection is frozen while that switch runs in PWM mode
                if (!m_ctrl[PWM_POS]) m_src[5:3] = d[5:3];
                if (!m_ctrl[SW2_BASE+PWM_POS]) m_src[2:0] = d[2:0];
            end
            default: ;
        endcase
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd_chk

    // Expected drive: enable and on, gated by the chosen channel in PWM mode
    function automatic logic [1:0] exp_sw();
        logic [1:0]  r;
        logic [15:0] c;
        logic [2:0]  s;
        for (int i = 0; i < 2; i++) begin
            c = m_ctrl[16*i +: 16];
            s = (i == 1) ? m_src[2:0] : m_src[5:3];
            r[i] = c[EN_POS] & c[ON_POS] & (!c[PWM_POS] | pwm_chan[s]) & !m_lp;
        end
        return r;
    endfunction : exp_sw

    // Hold each PWM level for half a 25 kHz period at least
    task automatic pwm_step();
        pwm_chan <= 8'($urandom);
        repeat (200) @(posedge ref_clk);
    endtask : pwm_step

    task automatic check_all();
        logic [1:0] e;
        repeat (3) @(posedge ref_clk);
        #1;
        e = exp_sw();
        check({30'h0, sw_out}, {30'h0, e});
        check({30'h0, sw_fast_slew}, {30'h0, m_ctrl[24], m_ctrl[8]});
        check({28'h0, oc_thresh}, {28'h0, m_ctrl[29:28], m_ctrl[13:12]});
        check({30'h0, ol_det_en}, {30'h0, m_ctrl[19], m_ctrl[3]});
        check({31'h0, irq}, {31'h0, |(m_sts & m_ien)});
        rd_chk(CTRL_OFS, m_ctrl);
        rd_chk(STS_OFS, m_sts);
        rd_chk(IEN_OFS, m_ien);
        rd_chk(SRC_OFS, m_src);
        rd_chk(TRIM1_OFS, m_trim1);
        rd_chk(TRIM2_OFS, m_trim2);
        rd_chk(STATUS_OFS, {29'h0, e, !m_lp});
    endtask : check_all

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // Watchdog well beyond the few thousand cycles the tests take
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        close_out();
    end

    // Main sequence
    initial begin
        int b;
        {wr_en, rd_en, low_power, addr, wdata, pwm_chan, m_lp} = '0;
        {short_cmd, hot_cmd, warm_cmd, open_cmd} = '0;
        {m_ctrl, m_sts, m_ien, m_src, m_trim1, m_trim2} = '0;
        n_fail = 0;
        n_compared = 0;
        rst_n = 1'b0;
        void'($urandom(32'hd0be51e4));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        check_all();
        wr(8'h30, 32'hffff_ffff);
        rd_chk(8'h30, 32'h0);
        rd_chk(CLR_OFS, 32'h0);
        $display("test reset done");
        // Random configurations; some source writes land while PWM is set
        for (int k = 0; k < 6; k++) begin
            pwm_step();
            wr(CTRL_OFS, $urandom);
            wr(SRC_OFS, $urandom);
            wr(IEN_OFS, $urandom);
            wr(TRIM1_OFS, $urandom);
            wr(TRIM2_OFS, $urandom);
            check_all();
        end
        $display("test random done");
        for (int k = 0; k < NUM_SRC; k++) begin
            wr(CTRL_OFS, 32'h0);
            wr(SRC_OFS, {26'h0, 3'(k), 3'(7 - k)});
            wr(CTRL_OFS, 32'h0007_0007);
            wr(SRC_OFS, 32'h0);
            pwm_step();
            check_all();
        end
        wr(CTRL_OFS, 32'h0003_0003);
        check_all();
        $display("test pwm done");
        wr(IEN_OFS, 32'h00f0_00f0);
        for (int i = 0; i < 2; i++) begin
            b = 16 * i;
            wr(CTRL_OFS, 32'h5 << b);
            short_cmd[i] <= 1'b1;
            m_ctrl = 32'h1 << b;
            m_sts = 32'h80 << b;
            check_all();
            wr(CLR_OFS, 32'h80 << b);
            check_all();
            wr(CTRL_OFS, 32'h5 << b);
            m_ctrl = 32'h1 << b;
            m_sts = 32'h80 << b;
            check_all();
            short_cmd[i] <= 1'b0;
            hot_cmd[i] <= 1'b1;
            wr(CLR_OFS, 32'h80 << b);
            wr(CTRL_OFS, 32'h5 << b);
            m_ctrl = 32'h1 << b;
            m_sts = 32'h2020 << b;
            check_all();
            wr(CLR_OFS, 32'h2020 << b);
            m_sts = 32'h2020 << b;
            check_all();
            hot_cmd[i] <= 1'b0;
            wr(CLR_OFS, 32'h2020 << b);
            wr(CTRL_OFS, 32'hd << b);
            warm_cmd[i] <= 1'b1;
            open_cmd[i] <= 1'b1;
            m_sts = 32'h5050 << b;
            check_all();
            warm_cmd[i] <= 1'b0;
            open_cmd[i] <= 1'b0;
            wr(CLR_OFS, 32'h0);
            check_all();
            wr(CLR_OFS, 32'h5050 << b);
            check_all();
        end
        $display("test faults done");
        wr(CTRL_OFS, 32'h0005_0005);
        low_power <= 1'b1;
        m_lp = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check({30'h0, sw_out}, 32'h0);
        rd_chk(STATUS_OFS, 32'h0);
        low_power <= 1'b0;
        m_lp = 1'b0;
        repeat (2) @(posedge ref_clk);
        check_all();
        $display("test low power done");
        close_out();
    end
endmodule : testbench

// *** src/low_side_switch_control.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Register file, protection and output control for two low-side switches
module low_side_switch_control
    import lss_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    input  wire logic [7:0]  pwm_chan,
    input  wire logic        low_power,
    input  wire logic [1:0]  oc_det,
    input  wire logic [1:0]  ot_det,
    input  wire logic [1:0]  ol_det,
    input  wire logic [1:0]  ot_warn,
    output logic      [1:0]  sw_out,
    output logic      [1:0]  sw_fast_slew,
    output logic      [3:0]  oc_thresh,
    output logic      [1:0]  ol_det_en,
    output logic             irq
);
    typedef enum logic [2:0] {
        PM_RUN   = 3'b001,
        PM_DOWN  = 3'b010,
        PM_WAKE  = 3'b100
    } pm_state_t;

    pm_state_t   pm_ff;
    logic [31:0] ctrl_ff;
    logic [31:0] sts_ff;
    logic [31:0] ien_ff;
    logic [31:0] src_ff;
    logic [31:0] trim1_ff;
    logic [31:0] trim2_ff;
    logic [1:0]  on_saved_ff;
    logic [1:0]  out_ff;
    logic [1:0]  pwm_gate;
    logic [1:0]  shut;
    logic [31:0] rd_mux;
    logic        wr_ctrl;
    logic        wr_clr;
    logic        wr_src;
    pwm_pick_if  pp ();

    // Per-switch field placement, used by several processes
    function automatic int fpos(input int sw, input int pos);
        return sw * SW2_BASE + pos;
    endfunction : fpos

    assign wr_ctrl = wr_en && (addr == CTRL_OFS);
    assign wr_clr  = wr_en && (addr == CLR_OFS);
    assign wr_src  = wr_en && (addr == SRC_OFS);

    // PWM channel selection
    assign pp.chan = pwm_chan;
    assign pp.sel1 = src_ff[5:3];
    assign pp.sel2 = src_ff[2:0];
    assign pwm_gate = pp.gate;
    pwm_pick u_pick (
        .pp (pp)
    );

    // Power-mode tracker: down in stop/sleep, one wake cycle to restore
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_ff <= PM_RUN;
        end else begin
            case (pm_ff)
                PM_RUN:  pm_ff <= low_power ? PM_DOWN : PM_RUN;
                PM_DOWN: pm_ff <= low_power ? PM_DOWN : PM_WAKE;
                PM_WAKE: pm_ff <= low_power ? PM_DOWN : PM_RUN;
                default: pm_ff <= PM_RUN;
            endcase
        end
    end

    // Remember which switches were on going into low power
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            on_saved_ff <= 2'b00;
        end else if (pm_ff == PM_RUN && low_power) begin
            on_saved_ff <= {ctrl_ff[fpos(1, ON_POS)], ctrl_ff[fpos(0, ON_POS)]};
        end
    end

    // Protection shutdown: open load deliberately excluded
    assign shut = oc_det | ot_det;

    // Control register; hardware fault clear of ON wins over a write
    generate
        for (genvar s = 0; s < 2; s++) begin : g_ctrl
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_ff[s*16 +: 16] <= RESET_VAL[15:0];
                end else begin
                    if (wr_ctrl) begin
                        ctrl_ff[s*16 +: 16] <= wdata[s*16 +: 16] & CTRL_MASK;
                    end
                    // Constant indices keep each loop pass sole writer of its own bits
                    if (pm_ff == PM_WAKE && on_saved_ff[s]) begin
                        ctrl_ff[s * SW2_BASE + ON_POS] <= 1'b1;
                    end
                    if (shut[s]) begin
                        ctrl_ff[s * SW2_BASE + ON_POS] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Status flags: set wins over clear, write-one clears
    generate
        for (genvar s = 0; s < 2; s++) begin : g_sts
            logic [15:0] setv;
            logic [15:0] clrv;
            always_comb begin
                setv = 16'h0000;
                setv[OC_IS_POS]  = oc_det[s];
                setv[OT_IS_POS]  = ot_det[s];
                setv[OT_ST_POS]  = ot_det[s];
                setv[OL_IS_POS]  = ol_det[s] & ctrl_ff[fpos(s, OL_EN_POS)];
                setv[OL_ST_POS]  = ol_det[s] & ctrl_ff[fpos(s, OL_EN_POS)];
                setv[PRE_IS_POS] = ot_warn[s];
                setv[PRE_ST_POS] = ot_warn[s];
            end
            assign clrv = wr_clr ? (wdata[s*16 +: 16] & STS_MASK) : 16'h0000;
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sts_ff[s*16 +: 16] <= RESET_VAL[15:0];
                end else begin
                    sts_ff[s*16 +: 16] <= (sts_ff[s*16 +: 16] & ~clrv) | setv;
                end
            end
        end
    endgenerate

    // Enable, source select and trim registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ien_ff   <= RESET_VAL;
            src_ff   <= RESET_VAL;
            trim1_ff <= RESET_VAL;
            trim2_ff <= RESET_VAL;
        end else if (wr_en) begin
            if (addr == IEN_OFS) begin
                ien_ff <= wdata & {IEN_MASK, IEN_MASK};
            end
            if (addr == TRIM1_OFS) begin
                trim1_ff <= wdata & TRIM_MASK;
            end
            if (addr == TRIM2_OFS) begin
                trim2_ff <= wdata & TRIM_MASK;
            end
            // Selection locked while its switch is in PWM mode, avoids glitching
            if (wr_src && !ctrl_ff[fpos(0, PWM_POS)]) begin
                src_ff[5:3] <= wdata[5:3];
            end
            if (wr_src && !ctrl_ff[fpos(1, PWM_POS)]) begin
                src_ff[2:0] <= wdata[2:0];
            end
        end
    end

    // Output stage: PWM has priority, fault or low power forces off
    generate
        for (genvar s = 0; s < 2; s++) begin : g_out
            logic on_b;
            logic pwm_b;
            logic run;
            assign on_b  = ctrl_ff[fpos(s, ON_POS)];
            assign pwm_b = ctrl_ff[fpos(s, PWM_POS)];
            assign run   = (pm_ff == PM_RUN) && ctrl_ff[fpos(s, EN_POS)];
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_ff[s] <= 1'b0;
                end else if (!run || low_power || shut[s]) begin
                    out_ff[s] <= 1'b0;
                end else if (pwm_b) begin
                    out_ff[s] <= on_b & pwm_gate[s];
                end else begin
                    out_ff[s] <= on_b;
                end
            end
        end
    endgenerate

    assign sw_out       = out_ff;
    assign sw_fast_slew = {ctrl_ff[fpos(1, SLEW_POS)], ctrl_ff[fpos(0, SLEW_POS)]};
    assign oc_thresh    = {ctrl_ff[fpos(1, OCSEL_POS) +: 2],
                           ctrl_ff[fpos(0, OCSEL_POS) +: 2]};
    assign ol_det_en    = {ctrl_ff[fpos(1, OL_EN_POS)], ctrl_ff[fpos(0, OL_EN_POS)]};

    // Interrupt: enabled flags, held until cleared
    assign irq = |(sts_ff & ien_ff);

    // Read mux; clear register and unmapped addresses read zero
    always_comb begin
        case (addr)
            CTRL_OFS:   rd_mux = ctrl_ff;
            STS_OFS:    rd_mux = sts_ff;
            IEN_OFS:    rd_mux = ien_ff;
            TRIM1_OFS:  rd_mux = trim1_ff;
            SRC_OFS:    rd_mux = src_ff;
            TRIM2_OFS:  rd_mux = trim2_ff;
            STATUS_OFS: rd_mux = {29'h0, out_ff, pm_ff == PM_RUN};
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data stands one cycle, then returns to zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= RESET_VAL;
        end else begin
            rdata <= rd_en ? rd_mux : 32'h0000_0000;
        end
    end

    // Fault must clear the on bit by the next edge
    a_oc_clears_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
        oc_det[0] |=> !ctrl_ff[ON_POS] && sts_ff[OC_IS_POS])
        else $error("overcurrent did not clear on bit");
    a_ot_forces_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ot_det[1] |=> !sw_out[1] && sts_ff[16 + OT_ST_POS])
        else $error("overtemperature did not force off");
    a_ol_no_shut: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ol_det[0] && !oc_det[0] && !ot_det[0] && ctrl_ff[ON_POS]
        |=> ctrl_ff[ON_POS] || $past(wr_ctrl))
        else $error("open load cleared on bit");
    a_lowpow_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        low_power |=> sw_out == 2'b00)
        else $error("switch on in low power");
    a_normal_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pm_ff == PM_RUN && !low_power && !shut[0] && ctrl_ff[EN_POS] && !ctrl_ff[PWM_POS]
        |=> sw_out[0] == $past(ctrl_ff[ON_POS]))
        else $error("normal mode output mismatch");
    a_pwm_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pm_ff == PM_RUN && !low_power && !shut[0] && ctrl_ff[EN_POS] && ctrl_ff[PWM_POS]
        |=> sw_out[0] == ($past(ctrl_ff[ON_POS]) & $past(pwm_gate[0])))
        else $error("pwm gating mismatch");
    a_clear_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_clr && wdata[OC_IS_POS] && !oc_det[0] |=> !sts_ff[OC_IS_POS])
        else $error("write one did not clear flag");
    a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ien_ff == 32'h0000_0000 |-> !irq) and (sts_ff[OC_IS_POS] && ien_ff[OC_IS_POS] |-> irq))
        else $error("interrupt not tied to enabled flags");
    a_wake_restore: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pm_ff == PM_WAKE && on_saved_ff[0] && !shut[0] |=> ctrl_ff[ON_POS])
        else $error("on bit not restored after wakeup");

    // Second switch sits at other indices, so it gets its own checks; overtemperature of the first switch is checked here too
    a_oc2_clears_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
        oc_det[1] |=> !ctrl_ff[SW2_BASE + ON_POS] && sts_ff[SW2_BASE + OC_IS_POS])
        else $error("overcurrent did not clear on bit of second switch");
    a_ot1_forces_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ot_det[0] |=> !sw_out[0] && !ctrl_ff[ON_POS] && sts_ff[OT_IS_POS] && sts_ff[OT_ST_POS])
        else $error("overtemperature did not force first switch off");
    a_ol2_no_shut: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ol_det[1] && !shut[1] && ctrl_ff[SW2_BASE + ON_POS]
        |=> ctrl_ff[SW2_BASE + ON_POS] || $past(wr_ctrl))
        else $error("open load cleared on bit of second switch");
    a_wake2_restore: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pm_ff == PM_WAKE && on_saved_ff[1] && !shut[1] |=> ctrl_ff[SW2_BASE + ON_POS])
        else $error("second on bit not restored after wakeup");
    a_pwm2_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pm_ff == PM_RUN && !low_power && !shut[1] && ctrl_ff[SW2_BASE + EN_POS]
        && ctrl_ff[SW2_BASE + PWM_POS]
        |=> sw_out[1] == ($past(ctrl_ff[SW2_BASE + ON_POS]) & $past(pwm_gate[1])))
        else $error("pwm gating mismatch on second switch");
    a_pwm_no_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl_ff[SW2_BASE + PWM_POS] && !ctrl_ff[SW2_BASE + ON_POS] |=> !sw_out[1])
        else $error("pwm drove switch with on bit clear");

    // Low power entry and the saved state used on wakeup
    a_save_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pm_ff == PM_RUN && low_power
        |=> on_saved_ff == {$past(ctrl_ff[SW2_BASE + ON_POS]), $past(ctrl_ff[ON_POS])})
        else $error("on state not saved on low power entry");
    a_down_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pm_ff != PM_RUN |-> sw_out == 2'b00)
        else $error("switch on outside run state");

    // Source select lock, flag setting and write-one-clear
    a_src_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_src && ctrl_ff[PWM_POS] |=> src_ff[5:3] == $past(src_ff[5:3]))
        else $error("source select changed while pwm set");
    a_src_takes: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_src && !ctrl_ff[SW2_BASE + PWM_POS] |=> src_ff[2:0] == $past(wdata[2:0]))
        else $error("source select write lost");
    a_ol_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ol_det[0] && ctrl_ff[OL_EN_POS] |=> sts_ff[OL_IS_POS] && sts_ff[OL_ST_POS])
        else $error("open load flags not set");
    a_warn2_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ot_warn[1] |=> sts_ff[SW2_BASE + PRE_IS_POS] && sts_ff[SW2_BASE + PRE_ST_POS])
        else $error("prewarning flags not set");
    a_w0_no_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_clr && !wdata[OT_ST_POS] && sts_ff[OT_ST_POS] |=> sts_ff[OT_ST_POS])
        else $error("write zero cleared a flag");

    // Register read port timing
    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rd_en |=> rdata == 32'h0000_0000)
        else $error("read data not zero without a read");
    a_rdata_sts: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_en && addr == STS_OFS |=> rdata == $past(sts_ff))
        else $error("status read data wrong");
endmodule : low_side_switch_control

// *** src/lss_pkg.sv ***
// Package with register map, field positions and reset values of the low-side switch block
// Functional notes
// - Normal mode: output follows output-on bit, protection active.
// - Normal mode runs while processor is in normal or slow-down mode.
// - Control bit selects PWM mode; protection stays active in PWM mode.
// - PWM mode needs both PWM-enable and output-on; selected channel gates output.
// - Source select register field chooses each switch's PWM channel.
// - Stop or sleep mode turns the switch off in hardware.
// - Configuration kept through stop; a switch that was on resumes after wakeup.
// - One slew bit picks slow or fast rate, also used in PWM mode.
// - Overcurrent threshold selectable among four settings.
// - Overcurrent turns switch off, sets flag, clears output-on bit.
// - Clearing a flag never re-enables; persisting fault shuts down again.
// - Overtemperature shuts switch down and sets its flag.
// - Overcurrent, overtemperature and open-load flags per switch.
// - Registers are byte addressed at their printed offsets.
// - PWM-enable bit takes priority over output-on bit.
// - Writing one to clear register clears matching flag; zero does nothing.
// - Open load sets a flag but does not shut the switch down.
package lss_pkg;
    localparam logic [7:0] CTRL_OFS    = 8'h04;
    localparam logic [7:0] STS_OFS     = 8'h08;
    localparam logic [7:0] CLR_OFS     = 8'h0c;
    localparam logic [7:0] IEN_OFS     = 8'h10;
    localparam logic [7:0] TRIM1_OFS   = 8'h18;
    localparam logic [7:0] SRC_OFS     = 8'h1c;
    localparam logic [7:0] TRIM2_OFS   = 8'h20;
    localparam logic [7:0] STATUS_OFS  = 8'h24;
    // Control fields, per switch at base 0 (switch 1) and 16 (switch 2)
    localparam int          SW2_BASE   = 16;
    localparam int          EN_POS     = 0;
    localparam int          PWM_POS    = 1;
    localparam int          ON_POS     = 2;
    localparam int          OL_EN_POS  = 3;
    localparam int          SLEW_POS   = 8;
    localparam int          OCSEL_POS  = 12;
    // Status fields, per switch
    localparam int          PRE_IS_POS = 4;
    localparam int          OT_IS_POS  = 5;
    localparam int          OL_IS_POS  = 6;
    localparam int          OC_IS_POS  = 7;
    localparam int          PRE_ST_POS = 12;
    localparam int          OT_ST_POS  = 13;
    localparam int          OL_ST_POS  = 14;
    localparam logic [15:0] CTRL_MASK  = 16'h310f;
    localparam logic [15:0] STS_MASK   = 16'h70f0;
    localparam logic [15:0] IEN_MASK   = 16'h00f0;
    localparam logic [31:0] TRIM_MASK  = 32'h0000_ffff;
    localparam logic [31:0] RESET_VAL  = 32'h0000_0000;
    localparam int          SRC_W      = 3;
    localparam int          NUM_SRC    = 8;
endpackage : lss_pkg

// *** src/pwm_pick.sv ***
`timescale 1ns/1ps
// Picks the PWM channel that gates each switch
module pwm_pick
    import lss_pkg::*;
(
    pwm_pick_if.picker pp
);
    // Plain index into the capture/compare outputs
    assign pp.gate[0] = pp.chan[pp.sel1];
    assign pp.gate[1] = pp.chan[pp.sel2];
endmodule : pwm_pick

// *** src/pwm_pick_if.sv ***
`timescale 1ns/1ps
// Interface carrying PWM channels and per-switch selections to the picker
interface pwm_pick_if;
    logic [7:0] chan;
    logic [2:0] sel1;
    logic [2:0] sel2;
    logic [1:0] gate;
    modport picker (input chan, input sel1, input sel2, output gate);
    modport user   (output chan, output sel1, output sel2, input gate);
endinterface : pwm_pick_if
